//--- rtl/edge_sync.sv
// Two-stage synchroniser with a rising-edge pulse output.
`timescale 1ns/1ps
module edge_sync (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic din,
  output logic      rise
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign rise = s2_r & ~s3_r;
endmodule

//--- rtl/host_proc_irq_status.sv
// Event status, mask and interrupt pin logic of the host-controller side.
`timescale 1ns/1ps
module host_proc_irq_status
  import irq_pkg::*;
#(
  parameter int CLKRDY_CYC = CLKRDY_TYP_CYC
) (
  input  wire logic  clk,
  input  wire logic  rst_b,
  proc_bus_if.dev    bus,
  input  wire logic  wakeup_sent,
  input  wire logic  suspended_in,
  input  wire logic  op_reg_event,
  input  wire logic  ext_eot,
  input  wire logic  byte_xfer,
  input  wire logic  async_ready,
  input  wire logic  sof_tick
);
  // ==========================================================
  // Event inputs wakeup_sent, suspended_in and ext_eot pass two flip-flops first.
  localparam int N_ASYNC = 3;

  logic [N_ASYNC-1:0] async_in;
  logic [N_ASYNC-1:0] async_rise;
  logic               ext_eot_rise;
  logic               susp_rise;
  logic               wake_rise;

  assign async_in     = {wakeup_sent, suspended_in, ext_eot};
  assign ext_eot_rise = async_rise[0];
  assign susp_rise    = async_rise[1];
  assign wake_rise    = async_rise[2];

  for (genvar g = 0; g < N_ASYNC; g++) begin : g_sync
    edge_sync u_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .din   (async_in[g]),
      .rise  (async_rise[g])
    );
  end

  // ==========================================================
  // Register decode.
  logic [DATA_W-1:0] stat_r;
  logic [DATA_W-1:0] stat_nxt;
  logic [DATA_W-1:0] mask_r;
  logic [DATA_W-1:0] cfg_r;
  logic [DATA_W-1:0] cnt_r;
  logic [DATA_W-1:0] done_r;
  logic [31:0]       wait_r;
  logic              waiting_r;
  logic [DATA_W-1:0] rd_data_r;
  logic              rd_valid_r;
  logic              pin_r;
  logic              req_d_r;
  logic [1:0]        pulse_r;

  wire wr       = bus.cmd_valid & bus.cmd_write;
  wire rd       = bus.cmd_valid & ~bus.cmd_write;
  wire stat_wr  = wr & (bus.cmd_code == CMD_STAT_WR);
  wire mask_wr  = wr & (bus.cmd_code == CMD_MASK_WR);
  wire cfg_wr   = wr & (bus.cmd_code == CMD_CFG_WR);
  wire cnt_wr   = wr & (bus.cmd_code == CMD_CNT_WR);

  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    case (bus.cmd_code)
      CMD_STAT_RD: rd_mux = stat_r;
      CMD_MASK_RD: rd_mux = mask_r;
      CMD_CFG_RD:  rd_mux = cfg_r;
      CMD_CNT_RD:  rd_mux = cnt_r;
      default:     rd_mux = '0;
    endcase
  end

  // ==========================================================
  // Clock-ready wait after wake-up.
  wire clk_ready_evt = waiting_r & (wait_r == 32'(CLKRDY_CYC - 1));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      waiting_r <= 1'b0;
      wait_r    <= '0;
    end else if (wake_rise) begin
      waiting_r <= 1'b1;
      wait_r    <= '0;
    end else if (clk_ready_evt) begin
      waiting_r <= 1'b0;
    end else if (waiting_r) begin
      wait_r    <= wait_r + 32'd1;
    end
  end

  // ==========================================================
  // Byte counting produces the internal end-of-transfer.
  wire int_eot = byte_xfer & (cnt_r != '0) &
                 (done_r + 16'd1 == cnt_r);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_r  <= '0;
      done_r <= '0;
    end else if (cnt_wr) begin
      cnt_r  <= bus.wr_data;
      done_r <= '0;
    end else if (int_eot) begin
      done_r <= '0;
    end else if (byte_xfer) begin
      done_r <= done_r + 16'd1;
    end
  end

  // ==========================================================
  // Sticky flags: set wins over clear.
  logic [DATA_W-1:0] set_vec;
  always_comb begin
    set_vec = '0;
    set_vec[BIT_FRAME_ISO] = sof_tick;
    set_vec[BIT_ASYNC]     = async_ready;
    set_vec[BIT_XFER_DONE] = int_eot | ext_eot_rise;
    set_vec[BIT_OP_REG]    = op_reg_event;
    set_vec[BIT_SUSPENDED] = susp_rise;
    set_vec[BIT_CLK_READY] = clk_ready_evt;
  end

  wire [DATA_W-1:0] clr_vec = stat_wr ? bus.wr_data : '0;
  assign stat_nxt = ((stat_r & ~clr_vec) | set_vec) & EVENT_BITS;

  // ==========================================================
  // Interrupt request and pin signalling.
  wire req  = |(stat_r & mask_r) & cfg_r[CFG_PIN_EN];
  wire edge_mode = cfg_r[CFG_EDGE];
  wire assert_now = edge_mode ? (pulse_r != 2'd0) : req;
  wire pin_nxt = cfg_r[CFG_POL_HIGH] ? assert_now : ~assert_now;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pulse_r <= '0;
      req_d_r <= 1'b0;
    end else begin
      req_d_r <= req;
      if (req & ~req_d_r)
        pulse_r <= 2'(PULSE_CYC);
      else if (pulse_r != 2'd0)
        pulse_r <= pulse_r - 2'd1;
    end
  end

  // ==========================================================
  // Registers written over the bus.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stat_r <= STAT_RESET;
      mask_r <= MASK_RESET;
      cfg_r  <= CFG_RESET;
    end else begin
      stat_r <= stat_nxt;
      if (mask_wr)
        mask_r <= bus.wr_data & EVENT_BITS;
      if (cfg_wr)
        cfg_r  <= bus.wr_data & CFG_BITS;
    end
  end

  // ==========================================================
  // Read answer: data stands for one cycle and is zero otherwise.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_data_r  <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_data_r  <= rd ? rd_mux : '0;
      rd_valid_r <= rd;
    end
  end

  // The pin starts at the idle level of the reset polarity.
  always_ff @(posedge clk) begin
    if (!rst_b)
      pin_r <= ~CFG_RESET[CFG_POL_HIGH];
    else
      pin_r <= pin_nxt;
  end

  assign bus.rd_data      = rd_data_r;
  assign bus.rd_valid     = rd_valid_r;
  assign bus.host_irq_pin = pin_r;
endmodule

//--- rtl/irq_pkg.sv
// Package with command codes, bit positions and timing constants.
package irq_pkg;
  localparam int          DATA_W         = 16;
  localparam logic [7:0]  CMD_STAT_RD    = 8'h24;
  localparam logic [7:0]  CMD_STAT_WR    = 8'hA4;
  localparam logic [7:0]  CMD_MASK_RD    = 8'h25;
  localparam logic [7:0]  CMD_MASK_WR    = 8'hA5;
  localparam logic [7:0]  CMD_CFG_RD     = 8'h20;
  localparam logic [7:0]  CMD_CFG_WR     = 8'hA0;
  localparam logic [7:0]  CMD_CNT_RD     = 8'h22;
  localparam logic [7:0]  CMD_CNT_WR     = 8'hA2;
  localparam logic [15:0] CLEAR_ALL      = 16'h00FF;
  localparam int          BIT_FRAME_ISO  = 0;
  localparam int          BIT_ASYNC      = 1;
  localparam int          BIT_XFER_DONE  = 2;
  localparam int          BIT_OP_REG     = 4;
  localparam int          BIT_SUSPENDED  = 5;
  localparam int          BIT_CLK_READY  = 6;
  localparam logic [15:0] EVENT_BITS     = 16'h0077;
  localparam logic [15:0] STAT_RESET     = 16'h0000;
  localparam logic [15:0] MASK_RESET     = 16'h0000;
  localparam logic [15:0] CFG_RESET      = 16'h0000;
  localparam int          CFG_PIN_EN     = 0;
  localparam int          CFG_EDGE       = 1;
  localparam int          CFG_POL_HIGH   = 2;
  localparam logic [15:0] CFG_BITS       = 16'h0007;
  localparam int          CLK_MHZ        = 50;
  localparam int          CLKRDY_MAX_US  = 1000;
  localparam int          CLKRDY_TYP_US  = 160;
  localparam int          CLKRDY_TYP_CYC = CLKRDY_TYP_US * CLK_MHZ;
  localparam int          CLKRDY_MAX_CYC = CLKRDY_MAX_US * CLK_MHZ;
  localparam int          PULSE_CYC      = 2;
endpackage

//--- rtl/proc_bus_if.sv
// Interface joining the processor end and the interrupt-status end.
`timescale 1ns/1ps
interface proc_bus_if;
  import irq_pkg::*;
  logic              cmd_valid;
  logic              cmd_write;
  logic [7:0]        cmd_code;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_data;
  logic              rd_valid;
  logic              host_irq_pin;
  modport dev  (input cmd_valid, cmd_write, cmd_code, wr_data,
                output rd_data, rd_valid, host_irq_pin);
  modport proc (output cmd_valid, cmd_write, cmd_code, wr_data,
                input rd_data, rd_valid, host_irq_pin);
endinterface

//--- rtl/proc_end.sv
// Processor-side end: issues register commands and reports the pin.
`timescale 1ns/1ps
module proc_end
  import irq_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  proc_bus_if.proc               bus,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [7:0]        req_code,
  input  wire logic [DATA_W-1:0] req_data,
  output logic                   req_ready,
  output logic [DATA_W-1:0]      resp_data,
  output logic                   resp_valid,
  output logic                   irq_level
);
  typedef enum logic [1:0] {IDLE, WAIT} st_t;
  st_t               st_r;
  logic              valid_r;
  logic              write_r;
  logic [7:0]        code_r;
  logic [DATA_W-1:0] data_r;
  logic [DATA_W-1:0] resp_r;
  logic              resp_v_r;
  logic              pin_s1_r;
  logic              pin_s2_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r     <= IDLE;
      valid_r  <= 1'b0;
      write_r  <= 1'b0;
      code_r   <= '0;
      data_r   <= '0;
      resp_r   <= '0;
      resp_v_r <= 1'b0;
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end else begin
      pin_s1_r <= bus.host_irq_pin;
      pin_s2_r <= pin_s1_r;
      resp_v_r <= 1'b0;
      valid_r  <= 1'b0;
      case (st_r)
        IDLE: begin
          if (req_valid) begin
            valid_r <= 1'b1;
            write_r <= req_write;
            code_r  <= req_code;
            data_r  <= req_data;
            st_r    <= req_write ? IDLE : WAIT;
          end
        end
        WAIT: begin
          if (bus.rd_valid) begin
            resp_r   <= bus.rd_data;
            resp_v_r <= 1'b1;
            st_r     <= IDLE;
          end
        end
        default: st_r <= IDLE;
      endcase
    end
  end

  assign req_ready     = (st_r == IDLE);
  assign bus.cmd_valid = valid_r;
  assign bus.cmd_write = write_r;
  assign bus.cmd_code  = code_r;
  assign bus.wr_data   = data_r;
  assign resp_data     = resp_r;
  assign resp_valid    = resp_v_r;
  assign irq_level     = pin_s2_r;
endmodule

//--- sim/host_proc_irq_status_bench.sv
// Self-checking bench joining the processor end to the status end.
`timescale 1ns/1ps
module host_proc_irq_status_bench;
  import irq_pkg::*;
  logic        clk;
  logic        rst_b;
  logic        req_valid;
  logic        req_write;
  logic [7:0]  req_code;
  logic [15:0] req_data;
  logic        req_ready;
  logic [15:0] resp_data;
  logic        resp_valid;
  logic        irq_level;
  logic [6:0]  ev;
  logic [15:0] q;
  logic [31:0] r;
  logic [31:0] seed = 32'h0000BD80;
  int          k;
  int          miscompares = 0;
  int          tests_run = 0;
  proc_bus_if bus_if ();
  proc_end proc_end_inst (.clk(clk), .rst_b(rst_b), .bus(bus_if),
    .req_valid(req_valid), .req_write(req_write), .req_code(req_code),
    .req_data(req_data), .req_ready(req_ready), .resp_data(resp_data),
    .resp_valid(resp_valid), .irq_level(irq_level));
  host_proc_irq_status #(.CLKRDY_CYC(10)) host_proc_irq_status_inst (
    .clk(clk), .rst_b(rst_b), .bus(bus_if), .wakeup_sent(ev[6]),
    .suspended_in(ev[5]), .op_reg_event(ev[4]), .ext_eot(ev[2]),
    .byte_xfer(ev[3]), .async_ready(ev[1]), .sof_tick(ev[0]));
  host_proc_irq_status_monitor monitor_inst (.clk(clk), .rst_b(rst_b),
    .cmd_valid(bus_if.cmd_valid), .cmd_write(bus_if.cmd_write),
    .cmd_code(bus_if.cmd_code), .wr_data(bus_if.wr_data),
    .rd_data(bus_if.rd_data), .rd_valid(bus_if.rd_valid),
    .host_irq_pin(bus_if.host_irq_pin));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Level-mode pin for random mask, config and fired event bits.
  function automatic logic pin_exp(input logic [31:0] v);
    logic [15:0] s;
    logic        req;
    s = {11'h000, v[23], 2'h0, v[21:20]};
    req = |(s & v[15:0] & EVENT_BITS) && v[16];
    return v[18] ? req : !req;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic w, input logic [7:0] c,
                    input logic [15:0] d, output logic [15:0] o);
    int n;
    @(negedge clk);
    req_valid = 1'b1;
    req_write = w;
    req_code = c;
    req_data = d;
    for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    for (n = 0; n < 50 && !w && resp_valid !== 1'b1; n++) @(negedge clk);
    o = resp_data;
  endtask
  task automatic fire(input int b);
    @(negedge clk);
    ev[b] = 1'b1;
    repeat ((b == 2 || b > 4) ? 3 : 1) @(negedge clk);
    ev[b] = 1'b0;
    repeat (20) @(negedge clk);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #(20 * 20000);
    miscompares++;
    summarize();
  end
  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_code = 8'h00;
    req_data = 16'h0000;
    ev = 7'h00;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    op(1'b0, CMD_STAT_RD, 16'h0000, q);
    chk(q, STAT_RESET);
    op(1'b0, CMD_MASK_RD, 16'h0000, q);
    chk(q, MASK_RESET);
    chk({15'h0000, irq_level}, 16'h0001);
    for (int b = 0; b < 7; b++) begin
      if (b != 3) begin
        op(1'b1, CMD_STAT_WR, CLEAR_ALL, q);
        fire(b);
        op(1'b0, CMD_STAT_RD, 16'h0000, q);
        chk(q, 16'h0001 << b);
        op(1'b0, CMD_STAT_RD, 16'h0000, q);
        chk(q, 16'h0001 << b);
      end
    end
    op(1'b1, CMD_STAT_WR, CLEAR_ALL, q);
    fire(0);
    fire(1);
    op(1'b1, CMD_STAT_WR, 16'hFF01, q);
    op(1'b0, CMD_STAT_RD, 16'h0000, q);
    chk(q, 16'h0002);
    op(1'b0, 8'h30, 16'h0000, q);
    chk(q, 16'h0000);
    k = 2 + int'(rnd() % 6);
    op(1'b1, CMD_STAT_WR, CLEAR_ALL, q);
    op(1'b1, CMD_CNT_WR, 16'(k), q);
    op(1'b0, CMD_CNT_RD, 16'h0000, q);
    chk(q, 16'(k));
    repeat (k - 1) fire(3);
    op(1'b0, CMD_STAT_RD, 16'h0000, q);
    chk(q, 16'h0000);
    fire(3);
    op(1'b0, CMD_STAT_RD, 16'h0000, q);
    chk(q, 16'h0004);
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      op(1'b1, CMD_STAT_WR, CLEAR_ALL, q);
      op(1'b1, CMD_MASK_WR, r[15:0], q);
      op(1'b1, CMD_CFG_WR, r[31:16] & 16'h0005, q);
      op(1'b0, CMD_MASK_RD, 16'h0000, q);
      chk(q, r[15:0] & EVENT_BITS);
      if (r[20]) fire(0);
      if (r[21]) fire(1);
      if (r[23]) fire(4);
      repeat (8) @(negedge clk);
      chk({15'h0000, irq_level}, {15'h0000, pin_exp(r)});
    end
    op(1'b1, CMD_STAT_WR, CLEAR_ALL, q);
    op(1'b1, CMD_MASK_WR, 16'h0001, q);
    op(1'b1, CMD_CFG_WR, 16'h0003, q);
    op(1'b0, CMD_CFG_RD, 16'h0000, q);
    chk(q, 16'h0003);
    ev[0] = 1'b1;
    @(negedge clk);
    ev[0] = 1'b0;
    k = 0;
    repeat (12) begin
      @(negedge clk);
      k += !irq_level;
    end
    chk(16'(k), 16'h0002);
    summarize();
  end
endmodule

//--- sim/host_proc_irq_status_monitor.sv
// Checker of the command bus and interrupt pin between the two ends.
`timescale 1ns/1ps
module host_proc_irq_status_monitor
  import irq_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              cmd_valid,
  input wire logic              cmd_write,
  input wire logic [7:0]        cmd_code,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic              rd_valid,
  input wire logic              host_irq_pin
);
  logic [2:0]  cfg_r;
  logic [15:0] mask_r;
  logic [1:0]  quiet_r;
  logic [7:0]  code_r;
  logic [15:0] seen_r;
  wire         rd_cmd   = cmd_valid && !cmd_write;
  wire         wr_cfg   = cmd_valid && cmd_write && cmd_code == CMD_CFG_WR;
  wire         wr_msk   = cmd_valid && cmd_write && cmd_code == CMD_MASK_WR;
  wire         wr_stat  = cmd_valid && cmd_write && cmd_code == CMD_STAT_WR;
  wire         stat_ans = rd_valid && code_r == CMD_STAT_RD;
  wire         rd_known = code_r inside {CMD_STAT_RD, CMD_MASK_RD,
                                         CMD_CFG_RD, CMD_CNT_RD};
  wire         idle_lvl = !cfg_r[2];
  // Shadow of config and mask, and a count of cycles since they changed.
  always_ff @(posedge clk) begin
    code_r <= cmd_code;
    if (!rst_b) begin
      cfg_r   <= 3'h0;
      mask_r  <= 16'h0000;
      quiet_r <= 2'h0;
      seen_r  <= 16'h0000;
    end else begin
      if (wr_cfg) cfg_r <= wr_data[2:0];
      if (wr_msk) mask_r <= wr_data & EVENT_BITS;
      if (wr_cfg || wr_msk) quiet_r <= 2'h0;
      else if (quiet_r != 2'h3) quiet_r <= quiet_r + 2'h1;
      if (wr_stat) seen_r <= 16'h0000;
      else if (stat_ans) seen_r <= rd_data;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_rd_answer; rd_cmd |=> rd_valid; endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered");
  property p_rd_cause; rd_valid |-> $past(rd_cmd); endproperty
  a_rd_cause: assert property (p_rd_cause)
    else $error("answer without read");
  property p_no_clear; stat_ans |-> (rd_data & seen_r) == seen_r; endproperty
  a_no_clear: assert property (p_no_clear)
    else $error("flag lost without write");
  property p_rsvd;
    stat_ans || (rd_valid && code_r == CMD_MASK_RD)
      |-> (rd_data & ~EVENT_BITS) == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bit set");
  property p_cfg_rsvd;
    rd_valid && code_r == CMD_CFG_RD |-> rd_data[15:3] == 13'h0;
  endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd)
    else $error("config reserved bit set");
  property p_unknown;
    rd_valid && !rd_known |-> rd_data == 16'h0000;
  endproperty
  a_unknown: assert property (p_unknown)
    else $error("unknown code read nonzero");
  property p_pin_off;
    quiet_r == 2'h3 && !cfg_r[0] |-> host_irq_pin == idle_lvl;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("pin active while disabled");
  property p_mask_off;
    quiet_r == 2'h3 && mask_r == 16'h0000 |-> host_irq_pin == idle_lvl;
  endproperty
  a_mask_off: assert property (p_mask_off)
    else $error("pin active with all masked");
  property p_edge;
    quiet_r == 2'h3 && cfg_r[1:0] == 2'h3 && host_irq_pin != idle_lvl &&
      $past(host_irq_pin) == idle_lvl
      |=> host_irq_pin != idle_lvl ##1 host_irq_pin == idle_lvl;
  endproperty
  a_edge: assert property (p_edge)
    else $error("edge pulse length wrong");
endmodule
